/* File: tb.sv */
/*
  Self-checking bench of the overcurrent stage.
  Assumes the front end model and a single AHB-Lite slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vro_map.svh"
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin num_errors++; $display("ERROR %0t got %h exp %h",$time,a,b); end end
module tb;
  import vro_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, blk = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0] htrans = 2'h0, ph = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] i_lvl = '0, u_lvl = '0;
  wire  logic hready, hresp, meas_valid, block_in, event_valid, irq;
  wire  logic [31:0] hrdata;
  vro_meas_s meas;
  vro_out_s stage_out;
  vro_event_s event_out;
  int num_errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  vro_restrained_overcurrent_stage #(.STAMP_CYCLES(10)) i_vro_restrained_overcurrent_stage (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .meas(meas), .meas_valid(meas_valid), .block_in(block_in),
    .stage_out(stage_out), .event_out(event_out), .event_valid(event_valid), .irq(irq));
  vro_front_model i_vro_front_model (.clk(clk), .rst(rst), .i_lvl(i_lvl), .u_lvl(u_lvl),
    .ph(ph), .blk(blk), .meas(meas), .meas_valid(meas_valid), .block_in(block_in));
  // --------------------------------------------------------------------------
  // Bus and helpers
  // --------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic drive(input logic [15:0] i, input logic [15:0] u, input logic b);
    i_lvl <= i; u_lvl <= u; blk <= b;
    repeat (24) @(posedge clk); // Three samples, each seen by c3
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, 32'h0000_0000 | `VRO_CTRL_OFS, '0); `CHK(q, `VRO_CTRL_RST)
    bus(1'b0, 32'h0000_0020, '0); `CHK(q, `VRO_KNEE_I_RST)
    bus(1'b0, 32'h0000_0024, '0); `CHK(q, `VRO_KNEE_U_RST)
    bus(1'b0, 32'h0000_00FC, '0); `CHK(q, 32'h0000_0000)
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_level;
    ph <= 2'h2; drive(16'h0032, 16'h1770, 1'b0);
    bus(1'b0, 32'h0000_0004, '0); `CHK(q[31:16], 16'h0046)
    `CHK(stage_out, 3'b000)
  endtask
  task automatic t_ctrl_mode;
    bus(1'b1, 32'h0000_0024, 32'h07D0_07D0);
    drive(16'h0050, 16'h1770, 1'b0); `CHK(stage_out, 3'b000)
    drive(16'h0050, 16'h03E8, 1'b0); `CHK(stage_out.start, 1'b1)
    `CHK(irq, 1'b0)
    bus(1'b0, 32'h0000_0008, '0); `CHK(q[0], 1'b1)
    bus(1'b1, 32'h0000_0024, `VRO_KNEE_U_RST); drive(16'h0000, 16'h1770, 1'b0);
    bus(1'b1, 32'h0000_000C, 32'h0000_0007);
  endtask
  task automatic t_zero_delay;
    bus(1'b1, 32'h0000_0028, 32'h0000_0000); bus(1'b1, 32'h0000_0010, 32'h0000_0007);
    i_lvl <= 16'h0050;
    for (int n = 0; n < 40 && event_valid !== 1'b1; n++) @(posedge clk);
    `CHK({event_out.start_on, event_out.trip_on}, 2'b11)
    drive(16'h0050, 16'h1770, 1'b0); `CHK(stage_out, 3'b110)
    `CHK(irq, 1'b1)
    bus(1'b0, 32'h0000_0008, '0); `CHK(q[2:0], 3'b011)
    bus(1'b1, 32'h0000_000C, 32'h0000_0003); @(posedge clk); `CHK(irq, 1'b0)
    drive(16'h0044, 16'h1770, 1'b0); `CHK(stage_out.start, 1'b1)
    drive(16'h0043, 16'h1770, 1'b0); `CHK(stage_out.start, 1'b0)
  endtask
  task automatic t_block;
    drive(16'h0050, 16'h1770, 1'b1); `CHK(stage_out, 3'b001)
    bus(1'b0, 32'h0000_0014, '0); `CHK(q, 32'h0001_0002)
    bus(1'b0, 32'h0000_0018, '0); `CHK(q, 32'h0000_0001)
    bus(1'b1, 32'h0000_0014, 32'h0000_0000);
    bus(1'b0, 32'h0000_0018, '0); `CHK(q, 32'h0000_0000)
  endtask
  task automatic t_delay;
    bus(1'b1, 32'h0000_0028, 32'h0000_0005);
    drive(16'h0050, 16'h1770, 1'b0); `CHK(stage_out, 3'b100)
    drive(16'h0050, 16'h1770, 1'b1); `CHK(stage_out, 3'b001)
    drive(16'h0050, 16'h1770, 1'b0); repeat (45) @(posedge clk);
    `CHK(stage_out, 3'b110)
    drive(16'h0000, 16'h1770, 1'b0); bus(1'b1, 32'h0000_0028, 32'h8000_0014);
    drive(16'h02BC, 16'h1770, 1'b0); `CHK(stage_out, 3'b100)
    repeat (24) @(posedge clk); `CHK(stage_out, 3'b110)
    bus(1'b0, 32'h0000_001C, '0); `CHK(q, 32'h0000_02BC)
    bus(1'b1, 32'h0000_0000, 32'h0000_0003); bus(1'b0, 32'h0000_0000, '0);
    `CHK(q, 32'h0000_0003)
  endtask
  task automatic t_force;
    logic [2:0] exp;
    drive(16'h0000, 16'h1770, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      exp = (k == 0) ? 3'b000 : (k == 1) ? 3'b100 : (k == 2) ? 3'b110 : 3'b001;
      bus(1'b1, 32'h0000_0000, 32'h0000_0005 | (k << 4)); repeat (4) @(posedge clk);
      `CHK(stage_out, exp)
    end
  endtask
  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset; t_level; t_ctrl_mode; t_zero_delay; t_block; t_delay; t_force;
    give_verdict;
  end
  initial
  begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire

/* File: vro_front_model.sv */
/*
  Measurement front end and blocking matrix model for the stage.
  Assumes the bench sets the levels; one sample every 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Front end
// ----------------------------------------------------------------------------
module vro_front_model
  import vro_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] i_lvl,
  input  wire logic [15:0] u_lvl,
  input  wire logic [1:0]  ph,
  input  wire logic        blk,
  output vro_meas_s        meas,
  output logic             meas_valid,
  output logic             block_in
);
  logic [2:0] cnt;
  // Short spacing keeps the run brief; 5 ms pacing is not needed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt        <= 3'h0;
      meas_valid <= 1'b0;
      meas       <= '0;
      block_in   <= 1'b0;
    end
    else
    begin
      cnt        <= cnt + 3'h1;
      meas_valid <= (cnt == 3'h7);
      meas.ia    <= (ph == 2'h0) ? i_lvl : 16'h0000;
      meas.ib    <= (ph == 2'h1) ? i_lvl : 16'h0000;
      meas.ic    <= (ph == 2'h2) ? i_lvl : 16'h0000;
      meas.u_pos <= u_lvl;
      block_in   <= blk;
    end
  end
endmodule // vro_front_model
`default_nettype wire

/* File: vro_map.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  voltage-restrained overcurrent stage.
  Assumes byte addresses on a 32-bit AHB-Lite bus, low 8 address bits decoded.
*/
`ifndef VRO_MAP_SVH
`define VRO_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define VRO_CTRL_OFS       8'h00
`define VRO_STATUS_OFS     8'h04
`define VRO_IRQ_STAT_OFS   8'h08
`define VRO_IRQ_CLR_OFS    8'h0C
`define VRO_IRQ_EN_OFS     8'h10
`define VRO_CNT_ST_OFS     8'h14
`define VRO_CNT_BLK_OFS    8'h18
`define VRO_AVG_OFS        8'h1C
`define VRO_BANK_PAGE      4'h2
`define VRO_KNEE_I_WORD    2'h0
`define VRO_KNEE_U_WORD    2'h1
`define VRO_DELAY_WORD     2'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VRO_CTRL_EN_BIT    0
`define VRO_CTRL_GRP_BIT   1
`define VRO_CTRL_FEN_BIT   2
`define VRO_CTRL_FST_LSB   4
`define VRO_DELAY_INV_BIT  31
`define VRO_IRQ_START_BIT  0
`define VRO_IRQ_TRIP_BIT   1
`define VRO_IRQ_BLK_BIT    2

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define VRO_CTRL_RST       32'h0000_0001
`define VRO_KNEE_I_RST     32'h0078_0014
`define VRO_KNEE_U_RST     32'h2710_07D0
`define VRO_DELAY_RST      32'h0000_0064
`define VRO_CODE_NORMAL    2'h0
`define VRO_CODE_START     2'h1
`define VRO_CODE_TRIP      2'h2
`define VRO_CODE_BLOCKED   2'h3

// ----------------------------------------------------------------------------
// Timing and ratios
// ----------------------------------------------------------------------------
`define VRO_CLK_PERIOD_NS  10
`define VRO_STAMP_NS       1000000
`define VRO_RESET_PCT      24'h61
`define VRO_FULL_PCT       24'h64
`define VRO_AVG_WINDOW_MS  20
`define VRO_MEAS_BASE_MS   5

`endif

/* File: vro_pkg.sv */
/*
  Types shared by the voltage-restrained overcurrent stage.
  Assumes vro_map.svh for numeric constants.
*/
`default_nettype none
package vro_pkg;

  // --------------------------------------------------------------------------
  // Stage state, Gray along normal-start-trip
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VRO_NORMAL  = 2'h0,
    VRO_START   = 2'h1,
    VRO_TRIP    = 2'h3,
    VRO_BLOCKED = 2'h2
  } vro_stage_e;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
    logic [15:0] u_pos;
  } vro_meas_s;

  typedef struct packed {
    logic [31:0] knee_i;
    logic [31:0] knee_u;
    logic [31:0] delay;
  } vro_bank_s;

  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } vro_out_s;

  typedef struct packed {
    logic        start_on;
    logic        start_off;
    logic        trip_on;
    logic        trip_off;
    logic        block_on;
    logic        block_off;
    logic [31:0] stamp_ms;
  } vro_event_s;

endpackage

`default_nettype wire

/* File: vro_restrained_overcurrent_stage.sv */
/*
  Voltage-restrained overcurrent stage with AHB-Lite register slave, event
  stamping, counters and interrupt.
  Assumes a front end that presents all four magnitudes with a one-cycle
  meas_valid every 5 ms, and a blocking matrix driving block_in.
*/
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
// Overview of operation
// - Upper knee voltage above lower knee gives restrained mode, level rises with voltage.
// - Equal knee voltages give fixed level, active only below knee voltage.
// - Pick-up level comes from positive sequence voltage only.
// - Delay is definite or inverse; inverse uses current over present level.
// - Each of three phases is compared on its own.
// - Release below 97 % of present pick-up level.
// - Inputs are three phase RMS currents plus positive sequence voltage, 5 ms base.
// - A 20 ms trailing average of the highest current is kept.
// - Start, trip, blocked outputs with on and off events, 1 ms stamps.
// - Zero definite delay emits start and trip events together, same stamp.
// - Resettable counters count start, trip and blocked events.
// - Test forcing overrides outputs, not st: 0 normal, 1 start, 2 trip, 3 blocked.
// - General settings stay put when the setting group changes.
// - Outside test forcing, start only asserts while blocking is inactive.
// - Four shape settings, defaults 0.2 and 1.2 xIn, 20 % and 100 % Un.
// - Blocking at pick-up gives blocked; active start resets and its delay timer clears.
`timescale 1ns/1ps
`default_nettype none
`include "vro_map.svh"

module vro_restrained_overcurrent_stage
  import vro_pkg::*;
#(
  parameter int unsigned STAMP_CYCLES = `VRO_STAMP_NS / `VRO_CLK_PERIOD_NS
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire vro_meas_s   meas,
  input  wire logic        meas_valid,
  input  wire logic        block_in,
  output vro_out_s         stage_out,
  output vro_event_s       event_out,
  output logic             event_valid,
  output logic             irq
);

  localparam int AVG_DEPTH = `VRO_AVG_WINDOW_MS / `VRO_MEAS_BASE_MS;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] ctrl;
  logic [31:0] irq_stat;
  logic [31:0] irq_en;
  vro_bank_s   bank [2];
  logic [15:0] cnt_start;
  logic [15:0] cnt_trip;
  logic [15:0] cnt_blk;
  logic [15:0] avg;
  vro_stage_e  st;
  vro_stage_e  next_st;
  logic [15:0] level;

  wire addr_ph  = hsel & hready & htrans[1];
  wire [7:0] ra = haddr[7:0];
  wire ra_bank  = ra[7:5] == 3'(`VRO_BANK_PAGE >> 1);
  wire [31:0] rd_bank = (ra[3:2] == `VRO_KNEE_I_WORD) ? bank[ra[4]].knee_i :
                        (ra[3:2] == `VRO_KNEE_U_WORD) ? bank[ra[4]].knee_u :
                        (ra[3:2] == `VRO_DELAY_WORD)  ? bank[ra[4]].delay  : 32'h0;
  wire [31:0] rd_word = ra_bank                      ? rd_bank :
                        (ra == `VRO_CTRL_OFS)        ? ctrl :
                        (ra == `VRO_STATUS_OFS)      ? {level, 11'h0, st, 3'(stage_out)} :
                        (ra == `VRO_IRQ_STAT_OFS)    ? irq_stat :
                        (ra == `VRO_IRQ_EN_OFS)      ? irq_en :
                        (ra == `VRO_CNT_ST_OFS)      ? {cnt_trip, cnt_start} :
                        (ra == `VRO_CNT_BLK_OFS)     ? {16'h0, cnt_blk} :
                        (ra == `VRO_AVG_OFS)         ? {16'h0, avg} : 32'h0;

  wire wa_bank  = wr_pend & (wr_addr[7:5] == 3'(`VRO_BANK_PAGE >> 1));
  wire we_ctrl  = wr_pend & (wr_addr == `VRO_CTRL_OFS);
  wire we_clr   = wr_pend & (wr_addr == `VRO_IRQ_CLR_OFS);
  wire we_en    = wr_pend & (wr_addr == `VRO_IRQ_EN_OFS);
  wire we_cnt   = wr_pend & (wr_addr == `VRO_CNT_ST_OFS);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0;
    end
    else
    begin
      wr_pend <= addr_ph & hwrite;
      if (addr_ph)
      begin
        wr_addr <= ra;
        hrdata  <= hwrite ? 32'h0 : rd_word;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Settings: two group banks, general control kept outside them
  // --------------------------------------------------------------------------
  // Force fields live in ctrl, which no group switch touches
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl   <= `VRO_CTRL_RST;
      irq_en <= 32'h0;
      for (int g = 0; g < 2; g++)
      begin
        bank[g] <= '{`VRO_KNEE_I_RST, `VRO_KNEE_U_RST, `VRO_DELAY_RST};
      end
    end
    else
    begin
      if (we_ctrl)
        ctrl <= hwdata;
      if (we_en)
        irq_en <= hwdata;
      if (wa_bank && wr_addr[3:2] == `VRO_KNEE_I_WORD)
        bank[wr_addr[4]].knee_i <= hwdata;
      if (wa_bank && wr_addr[3:2] == `VRO_KNEE_U_WORD)
        bank[wr_addr[4]].knee_u <= hwdata;
      if (wa_bank && wr_addr[3:2] == `VRO_DELAY_WORD)
        bank[wr_addr[4]].delay <= hwdata;
    end
  end

  wire        enable  = ctrl[`VRO_CTRL_EN_BIT];
  wire        fen     = ctrl[`VRO_CTRL_FEN_BIT];
  wire [1:0]  fcode   = ctrl[`VRO_CTRL_FST_LSB +: 2];
  vro_bank_s  act;
  assign act = bank[ctrl[`VRO_CTRL_GRP_BIT]];
  wire [15:0] i_lo    = act.knee_i[15:0];
  wire [15:0] i_up    = act.knee_i[31:16];
  wire [15:0] u_lo    = act.knee_u[15:0];
  wire [15:0] u_up    = act.knee_u[31:16];
  wire        inverse = act.delay[`VRO_DELAY_INV_BIT];
  wire [15:0] dly     = act.delay[15:0];

  // --------------------------------------------------------------------------
  // Measurement latch and 1 ms stamp
  // --------------------------------------------------------------------------
  vro_meas_s   mq;
  logic        blk_q;
  logic        proc_q;
  logic        eval_q;
  logic [31:0] stamp;
  logic [31:0] pre_cnt;

  // Blocking is caught together with the new sample, before any comparison
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mq     <= '0;
      blk_q  <= 1'b0;
      proc_q <= 1'b0;
      eval_q <= 1'b0;
    end
    else
    begin
      proc_q <= meas_valid;
      eval_q <= proc_q;
      if (meas_valid)
      begin
        mq    <= meas;
        blk_q <= block_in;
      end
    end
  end

  wire stamp_tick = pre_cnt == 32'(STAMP_CYCLES - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_cnt <= 32'h0;
      stamp   <= 32'h0;
    end
    else
    begin
      pre_cnt <= stamp_tick ? 32'h0 : pre_cnt + 32'h1;
      if (stamp_tick)
        stamp <= stamp + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Pick-up level from positive sequence voltage
  // --------------------------------------------------------------------------
  wire        restrained = u_up > u_lo;
  wire [15:0] span       = restrained ? u_up - u_lo : 16'h0001;
  wire [15:0] du         = mq.u_pos - u_lo;
  wire [15:0] di         = (i_up > i_lo) ? i_up - i_lo : 16'h0;
  wire [31:0] quot       = (32'(di) * 32'(du)) / 32'(span);
  wire [15:0] interp     = i_lo + quot[15:0];
  // Controlled mode arms only under the knee; a reversed pair acts the same
  wire        armed      = enable & (restrained | (mq.u_pos < u_lo));

  assign level = !restrained          ? i_lo :
                 (mq.u_pos <= u_lo)   ? i_lo :
                 (mq.u_pos >= u_up)   ? i_up : interp;

  wire [23:0] lvl_pct  = 24'(level) * `VRO_FULL_PCT;
  wire [23:0] lvl_rel  = 24'(level) * `VRO_RESET_PCT;

  // --------------------------------------------------------------------------
  // Per-phase comparators with hysteresis
  // --------------------------------------------------------------------------
  logic [2:0]  pu;
  wire  [15:0] ph [3];
  assign ph[0] = mq.ia;
  assign ph[1] = mq.ib;
  assign ph[2] = mq.ic;

  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    wire [23:0] i_pct = 24'(ph[p]) * `VRO_FULL_PCT;
    wire hold  = i_pct >= lvl_rel;
    wire raise = i_pct > lvl_pct;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        pu[p] <= 1'b0;
      else if (proc_q)
        pu[p] <= armed & (pu[p] ? hold : raise);
    end
    chk_phase_hold : assert property (@(posedge clk) disable iff (rst)
      (proc_q && armed && pu[p] && hold) |=> pu[p])
      else $error("phase released above reset level");
  end

  wire        pickup = |pu;
  wire [15:0] imax_ab = (mq.ia > mq.ib) ? mq.ia : mq.ib;
  wire [15:0] imax    = (imax_ab > mq.ic) ? imax_ab : mq.ic;

  // --------------------------------------------------------------------------
  // Trailing average of the highest phase current
  // --------------------------------------------------------------------------
  logic [15:0] hist [AVG_DEPTH];
  wire  [17:0] hsum = 18'(hist[0]) + 18'(hist[1]) + 18'(hist[2]) + 18'(hist[3]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < AVG_DEPTH; k++)
        hist[k] <= 16'h0;
      avg <= 16'h0;
    end
    else if (proc_q)
    begin
      hist[0] <= imax;
      for (int k = 1; k < AVG_DEPTH; k++)
        hist[k] <= hist[k-1];
      avg <= hsum[17:2];
    end
  end

  // --------------------------------------------------------------------------
  // Delay timers
  // --------------------------------------------------------------------------
  // Inverse: integrate (I - Ip) per 5 ms until it reaches k * Ip, so that
  // t = k / (I/Ip - 1) with no divider in the loop
  logic [31:0] delay_ms;
  logic [31:0] acc;
  wire  [31:0] target  = 32'(dly) * 32'(level);
  wire  [15:0] excess  = (imax > level) ? imax - level : 16'h0;
  wire         timer_done = inverse ? (acc >= target)
                                    : (delay_ms >= 32'(dly));
  wire         zero_dly = !inverse && dly == 16'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      delay_ms <= 32'h0;
      acc      <= 32'h0;
    end
    else if (st != VRO_START)
    begin
      delay_ms <= 32'h0;
      acc      <= 32'h0;
    end
    else
    begin
      if (stamp_tick)
        delay_ms <= delay_ms + 32'h1;
      if (eval_q)
        acc <= acc + 32'(excess);
    end
  end

  // --------------------------------------------------------------------------
  // Stage state machine
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st)
      VRO_NORMAL:
        if (eval_q && pickup)
          next_st = blk_q ? VRO_BLOCKED
                  : (zero_dly ? VRO_TRIP : VRO_START);
      VRO_START:
        if (eval_q && !pickup)
          next_st = VRO_NORMAL;
        else if (eval_q && blk_q)
          next_st = VRO_BLOCKED;
        else if (timer_done)
          next_st = VRO_TRIP;
      VRO_TRIP:
        if (eval_q && !pickup)
          next_st = VRO_NORMAL;
        else if (eval_q && blk_q)
          next_st = VRO_BLOCKED;
      VRO_BLOCKED:
        if (eval_q && !pickup)
          next_st = VRO_NORMAL;
        else if (eval_q && !blk_q)
          next_st = zero_dly ? VRO_TRIP : VRO_START;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= VRO_NORMAL;
    else
      st <= next_st;
  end

  // --------------------------------------------------------------------------
  // Outputs, forcing and events
  // --------------------------------------------------------------------------
  vro_out_s live;
  vro_out_s forced;
  vro_out_s eff;
  assign live   = '{(st == VRO_START) || (st == VRO_TRIP), st == VRO_TRIP,
                    st == VRO_BLOCKED};
  assign forced = '{(fcode == `VRO_CODE_START) || (fcode == `VRO_CODE_TRIP),
                    fcode == `VRO_CODE_TRIP, fcode == `VRO_CODE_BLOCKED};
  assign eff    = fen ? forced : live;

  wire [5:0] next_flags = {eff.start & ~stage_out.start, ~eff.start & stage_out.start,
                           eff.trip & ~stage_out.trip, ~eff.trip & stage_out.trip,
                           eff.blocked & ~stage_out.blocked,
                           ~eff.blocked & stage_out.blocked};

  // Same edge stamps every change, so start and trip share one time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage_out   <= '0;
      event_out   <= '0;
      event_valid <= 1'b0;
    end
    else
    begin
      stage_out   <= eff;
      event_out   <= {next_flags, stamp};
      event_valid <= |next_flags;
    end
  end

  // --------------------------------------------------------------------------
  // Counters and interrupt
  // --------------------------------------------------------------------------
  wire [2:0]  ev_set = event_valid ? {event_out.block_on, event_out.trip_on,
                                      event_out.start_on} : 3'h0;
  wire [31:0] clr    = we_clr ? hwdata : 32'h0;

  // A clear in the same cycle as a new event loses to the event
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_start <= 16'h0;
      cnt_trip  <= 16'h0;
      cnt_blk   <= 16'h0;
      irq_stat  <= 32'h0;
    end
    else
    begin
      cnt_start <= (we_cnt ? 16'h0 : cnt_start) + 16'(ev_set[`VRO_IRQ_START_BIT]);
      cnt_trip  <= (we_cnt ? 16'h0 : cnt_trip) + 16'(ev_set[`VRO_IRQ_TRIP_BIT]);
      cnt_blk   <= (we_cnt ? 16'h0 : cnt_blk) + 16'(ev_set[`VRO_IRQ_BLK_BIT]);
      irq_stat  <= (irq_stat & ~clr) | {29'h0, ev_set};
    end
  end

  assign irq = |(irq_stat & irq_en);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_block_no_start : assert property (@(posedge clk) disable iff (rst)
    (eval_q && blk_q && !fen) |-> ##2 (fen || !stage_out.start))
    else $error("start asserted while blocked");

  chk_zero_delay_pair : assert property (@(posedge clk) disable iff (rst)
    (st == VRO_NORMAL && next_st == VRO_TRIP && !fen) |-> ##2
    (event_valid && event_out.start_on && event_out.trip_on))
    else $error("zero delay start and trip split");

  chk_controlled_idle : assert property (@(posedge clk) disable iff (rst)
    (proc_q && !restrained && mq.u_pos >= u_lo) |=> (pu == 3'h0))
    else $error("controlled mode picked up above knee");

  chk_level_range : assert property (@(posedge clk) disable iff (rst)
    (restrained && i_up >= i_lo) |-> (level >= i_lo && level <= i_up))
    else $error("pick-up level outside knee currents");

  chk_definite_expiry : assert property (@(posedge clk) disable iff (rst)
    (st == VRO_START && !eval_q && !inverse && delay_ms >= 32'(dly)) |=> st == VRO_TRIP)
    else $error("definite delay did not trip");

  chk_force_code : assert property (@(posedge clk) disable iff (rst)
    (fen && fcode == `VRO_CODE_BLOCKED) ##1 $stable(ctrl) |->
    (stage_out.blocked && !stage_out.start && !stage_out.trip))
    else $error("forced blocked not shown");

  chk_start_count : assert property (@(posedge clk) disable iff (rst)
    (event_valid && event_out.start_on && !we_cnt) |=>
    cnt_start == $past(cnt_start) + 16'h1)
    else $error("start counter missed event");

  chk_trip_start : assert property (@(posedge clk) disable iff (rst)
    stage_out.trip |-> stage_out.start)
    else $error("trip without start");

  chk_irq_raise : assert property (@(posedge clk) disable iff (rst)
    (event_valid && event_out.trip_on && irq_en[`VRO_IRQ_TRIP_BIT]) |=> irq)
    else $error("trip interrupt not raised");

  chk_blk_release : assert property (@(posedge clk) disable iff (rst)
    (st == VRO_START && eval_q && pickup && blk_q) |=>
    (st == VRO_BLOCKED) ##1 (delay_ms == 32'h0))
    else $error("start not reset by blocking");

endmodule // vro_restrained_overcurrent_stage

`default_nettype wire
